//--- logic/event_timer_pkg.sv
package event_timer_pkg;

    // ----------------------------------------------------------------
    // Count clock selections
    // ----------------------------------------------------------------
    localparam logic [2:0] CSEL_MAIN      = 3'h0;
    localparam logic [2:0] CSEL_MAIN_DIV  = 3'h1;
    localparam logic [2:0] CSEL_T0_SUB    = 3'h3;
    localparam logic [2:0] CSEL_T0_MATCH  = 3'h4;
    localparam logic [2:0] CSEL_T0_WAVE   = 3'h5;
    localparam logic [2:0] CSEL_EXT       = 3'h2;
    localparam logic [2:0] CSEL_EXT_DIV2  = 3'h3;
    localparam logic [2:0] CSEL_EXT_DIV4  = 3'h4;
    localparam logic [2:0] CSEL_EXT_DIV8  = 3'h5;

    // ----------------------------------------------------------------
    // Operating modes
    // ----------------------------------------------------------------
    localparam logic [1:0] MODE_COUNTER   = 2'h0;
    localparam logic [1:0] MODE_PATTERN   = 2'h2;

    // ----------------------------------------------------------------
    // Prescaler width and taps; counter reset value
    // ----------------------------------------------------------------
    localparam int         MAIN_DIV_W     = 7;
    localparam int         TAP_DIV4       = 1;
    localparam int         TAP_DIV8       = 2;
    localparam int         TAP_DIV16      = 3;
    localparam int         TAP_DIV128     = 6;
    localparam logic [7:0] COUNT_RESET    = 8'h00;

endpackage

//--- logic/event_timers.sv
module event_timers (
    input  wire logic       clk_sys,
    input  wire logic       reset_n,
    input  wire logic       sub_clk_tick,
    input  wire logic       event_input_pin_a,
    input  wire logic       event_input_pin_c,
    input  wire logic       count_run_bit,
    input  wire logic       event_count_run_bit,
    input  wire logic       third_count_run_bit,
    input  wire logic [2:0] first_clksel,
    input  wire logic [2:0] second_clksel,
    input  wire logic [2:0] third_clksel,
    input  wire logic [1:0] first_opsel,
    input  wire logic [1:0] second_opsel,
    input  wire logic [1:0] third_opsel,
    input  wire logic [7:0] match_value_reg,
    input  wire logic [7:0] event_match_value_reg,
    input  wire logic [7:0] third_match_value_reg,
    output logic      [7:0] up_counter_value,
    output logic      [7:0] event_counter_value,
    output logic      [7:0] third_counter_value,
    output logic            match_irq,
    output logic            event_match_irq,
    output logic            third_match_irq
);

    // Square wave and pattern waveform outputs are not built
    typedef struct packed {
        logic [event_timer_pkg::MAIN_DIV_W-1:0] main_div;
        logic [1:0]                             pin_prev;
        logic [1:0][2:0]                        ext_div;
        logic [2:0][7:0]                        count;
        logic [2:0]                             irq;
        logic                                   second_wave;
    } state_t;

    state_t st_r;
    state_t st_nxt;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Pulse when the divider bits up to the tap are all ones, just before they wrap
    function automatic logic div_tick(input logic [event_timer_pkg::MAIN_DIV_W-1:0] d,
                                      input int tap);
        logic hit;
        hit = 1'b1;
        for (int i = 0; i < event_timer_pkg::MAIN_DIV_W; i++) begin
            if (i <= tap && !d[i]) begin
                hit = 1'b0;
            end
        end
        return hit;
    endfunction

    // External selections shared by the two event timers
    function automatic logic ext_tick(input logic [2:0] sel, input logic edge_hit,
                                      input logic [2:0] div);
        logic t;
        t = 1'b0;
        unique case (sel)
            event_timer_pkg::CSEL_EXT:      t = edge_hit;
            event_timer_pkg::CSEL_EXT_DIV2: t = edge_hit && div[0];
            event_timer_pkg::CSEL_EXT_DIV4: t = edge_hit && (&div[1:0]);
            event_timer_pkg::CSEL_EXT_DIV8: t = edge_hit && (&div[2:0]);
            default:                        t = 1'b0;
        endcase
        return t;
    endfunction

    // Codes 01 and 11 are refused: the timer is held as if stopped
    function automatic logic mode_legal(input logic [1:0] m);
        return m == event_timer_pkg::MODE_COUNTER
            || m == event_timer_pkg::MODE_PATTERN;
    endfunction

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    logic [2:0]       mode_ok;
    logic [2:0]       run;
    logic [2:0][7:0]  cmp;
    logic [2:0]       tick;
    logic [2:0]       hit;
    logic [1:0]       pin_now;
    logic [1:0]       edge_hit;
    logic [1:0][2:0]  sel_ev;

    always_comb begin
        // Pattern waveform is not built; its base counter still runs
        mode_ok = {mode_legal(third_opsel), mode_legal(second_opsel),
                   mode_legal(first_opsel)};
        run     = {third_count_run_bit, event_count_run_bit, count_run_bit} & mode_ok;
        cmp     = {third_match_value_reg, event_match_value_reg, match_value_reg};
        pin_now = {event_input_pin_c, event_input_pin_a};
        sel_ev  = {third_clksel, second_clksel};
        st_nxt  = st_r;
        st_nxt.main_div = st_r.main_div + 1'b1;
        st_nxt.pin_prev = pin_now;
        // Rising edge is the valid edge
        // Pins arrive synchronous, so one stage of history is enough
        edge_hit = pin_now & ~st_r.pin_prev;
        tick     = 3'b000;
        hit      = 3'b000;

        // ------------------------------------------------------------
        // Count clock selection
        // ------------------------------------------------------------
        // Second timer clock
        unique case (second_clksel)
            event_timer_pkg::CSEL_MAIN:     tick[1] = 1'b1;
            event_timer_pkg::CSEL_MAIN_DIV:
                tick[1] = div_tick(st_r.main_div, event_timer_pkg::TAP_DIV4);
            default: tick[1] = ext_tick(second_clksel, edge_hit[0], st_r.ext_div[0]);
        endcase

        // Third timer clock
        unique case (third_clksel)
            event_timer_pkg::CSEL_MAIN:     tick[2] = 1'b1;
            event_timer_pkg::CSEL_MAIN_DIV:
                tick[2] = div_tick(st_r.main_div, event_timer_pkg::TAP_DIV16);
            default: tick[2] = ext_tick(third_clksel, edge_hit[1], st_r.ext_div[1]);
        endcase

        // ------------------------------------------------------------
        // External prescalers
        // ------------------------------------------------------------
        // Cleared while stopped so a restart begins a whole divided period
        for (int k = 0; k < 2; k++) begin
            if (!run[k+1]) begin
                st_nxt.ext_div[k] = 3'h0;
            end else if (edge_hit[k] && sel_ev[k] != event_timer_pkg::CSEL_EXT) begin
                st_nxt.ext_div[k] = st_r.ext_div[k] + 1'b1;
            end
        end

        // ------------------------------------------------------------
        // Match detection
        // ------------------------------------------------------------
        // Second and third go first: the first timer may count the second's match
        for (int k = 1; k < 3; k++) begin
            hit[k] = run[k] && tick[k] && (st_r.count[k] == cmp[k]);
        end

        // First timer clock, including the second timer's match
        unique case (first_clksel)
            event_timer_pkg::CSEL_MAIN:     tick[0] = 1'b1;
            event_timer_pkg::CSEL_MAIN_DIV:
                tick[0] = div_tick(st_r.main_div, event_timer_pkg::TAP_DIV8);
            event_timer_pkg::CSEL_EXT:
                tick[0] = div_tick(st_r.main_div, event_timer_pkg::TAP_DIV128);
            event_timer_pkg::CSEL_T0_SUB:   tick[0] = sub_clk_tick;
            event_timer_pkg::CSEL_T0_MATCH: tick[0] = hit[1];
            // Output selection steps once per full output period
            event_timer_pkg::CSEL_T0_WAVE:  tick[0] = hit[1] && st_r.second_wave;
            default:                        tick[0] = 1'b0;
        endcase
        hit[0] = run[0] && tick[0] && (st_r.count[0] == cmp[0]);

        // ------------------------------------------------------------
        // Counters and match requests
        // ------------------------------------------------------------
        for (int k = 0; k < 3; k++) begin
            if (!run[k]) begin
                st_nxt.count[k] = event_timer_pkg::COUNT_RESET;
            end else if (hit[k]) begin
                st_nxt.count[k] = event_timer_pkg::COUNT_RESET;
            end else if (tick[k]) begin
                st_nxt.count[k] = st_r.count[k] + 1'b1;
            end
        end

        // One pulse per match; a match on every clock keeps it high
        st_nxt.irq = hit;

        // ------------------------------------------------------------
        // Second timer output
        // ------------------------------------------------------------
        // Internal only: toggles on match, low when stopped; no pin is driven
        if (!run[1]) begin
            st_nxt.second_wave = 1'b0;
        end else if (hit[1]) begin
            st_nxt.second_wave = !st_r.second_wave;
        end
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    // Asynchronous clear; every field starts at zero
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign up_counter_value    = st_r.count[0];
    assign event_counter_value = st_r.count[1];
    assign third_counter_value = st_r.count[2];
    assign match_irq           = st_r.irq[0];
    assign event_match_irq     = st_r.irq[1];
    assign third_match_irq     = st_r.irq[2];

endmodule

//--- test/pulse_source.sv
module pulse_source (
    input  wire logic       clk_sys,
    input  wire logic       enable,
    input  wire logic [3:0] period,
    output logic            pulse_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cnt_r = 4'h0;
    initial pulse_pin = 1'b0;
    // Quiet line while disabled, so no stray edge reaches the counter
    always @(negedge clk_sys) begin
        cnt_r <= (!enable || cnt_r == period - 4'h1) ? 4'h0 : cnt_r + 4'h1;
        pulse_pin <= enable && (cnt_r < period / 4'h2);
    end
endmodule

//--- test/event_timers_asserts.sv
module event_timers_asserts (
    input wire logic       clk_sys,
    input wire logic       reset_n,
    input wire logic       count_run_bit,
    input wire logic       event_count_run_bit,
    input wire logic       third_count_run_bit,
    input wire logic [2:0] first_clksel,
    input wire logic [1:0] first_opsel,
    input wire logic [7:0] match_value_reg,
    input wire logic [7:0] third_match_value_reg,
    input wire logic [7:0] up_counter_value,
    input wire logic [7:0] event_counter_value,
    input wire logic [7:0] third_counter_value,
    input wire logic       match_irq,
    input wire logic       event_match_irq,
    input wire logic       third_match_irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    a_first_clear: assert property (match_irq |-> up_counter_value == 8'h00)
        else $error("first counter not cleared on match");
    a_event_clear: assert property (event_match_irq |-> event_counter_value == 8'h00)
        else $error("event counter not cleared on match");
    a_first_cause: assert property (match_irq |->
        $past(up_counter_value) == $past(match_value_reg) && $past(count_run_bit))
        else $error("first request without match");
    a_third_cause: assert property (third_match_irq |->
        $past(third_counter_value) == $past(third_match_value_reg))
        else $error("third request without match");
    a_stop_zero: assert property (
        !count_run_bit |=> up_counter_value == 8'h00 && !match_irq)
        else $error("first counter not held at zero");
    a_event_stop: assert property (
        !event_count_run_bit |=> event_counter_value == 8'h00)
        else $error("event counter not held at zero");
    a_third_stop: assert property (
        !third_count_run_bit |=> third_counter_value == 8'h00)
        else $error("third counter not held at zero");
    a_main_step: assert property (
        $past(count_run_bit) && $past(first_clksel) == 3'h0 && $past(first_opsel) == 2'h0
        |-> up_counter_value == 8'($past(up_counter_value) + 8'h01) || match_irq)
        else $error("first counter missed a main clock step");
    a_event_step: assert property ($changed(event_counter_value) |->
        event_counter_value == 8'($past(event_counter_value) + 8'h01)
        || event_counter_value == 8'h00)
        else $error("event counter jumped");
    a_mode_hold: assert property (
        first_opsel[0] |=> up_counter_value == 8'h00 && !match_irq)
        else $error("first counter ran in a refused mode");
    c_back_to_back: cover property (match_irq ##1 match_irq);
    c_event_match: cover property (event_match_irq);
    c_third_match: cover property (third_match_irq);
endmodule
bind event_timers event_timers_asserts u_chk (.clk_sys, .reset_n, .count_run_bit,
    .event_count_run_bit, .third_count_run_bit, .first_clksel, .first_opsel, .match_value_reg,
    .third_match_value_reg, .up_counter_value, .event_counter_value, .third_counter_value,
    .match_irq, .event_match_irq, .third_match_irq);

//--- test/testbench.sv
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int EP = 6;
    localparam int SP = 5;
    logic       clk_sys = 1'b0;
    logic       reset_n = 1'b0;
    logic       sub_clk_tick = 1'b0;
    logic       src_en = 1'b0;
    logic [2:0] run = 3'h0;
    logic [2:0] sel [3] = '{3'h0, 3'h0, 3'h0};
    logic [7:0] cmp [3] = '{8'h00, 8'h00, 8'h00};
    logic [1:0] mode = event_timer_pkg::MODE_COUNTER;
    wire  logic       pin;
    wire  logic [7:0] cnt [3];
    wire  logic [2:0] irq;
    int err_total = 0, checks = 0, seed = 32'hb3d2, cyc = 0;
    pulse_source u_src (.clk_sys, .enable(src_en), .period(4'(EP)), .pulse_pin(pin));
    event_timers u_event_timers (.clk_sys, .reset_n, .sub_clk_tick,
        .event_input_pin_a(pin), .event_input_pin_c(pin), .count_run_bit(run[0]),
        .event_count_run_bit(run[1]), .third_count_run_bit(run[2]), .first_clksel(sel[0]),
        .second_clksel(sel[1]), .third_clksel(sel[2]), .first_opsel(mode),
        .second_opsel(mode), .third_opsel(mode), .match_value_reg(cmp[0]),
        .event_match_value_reg(cmp[1]), .third_match_value_reg(cmp[2]),
        .up_counter_value(cnt[0]), .event_counter_value(cnt[1]),
        .third_counter_value(cnt[2]), .match_irq(irq[0]), .event_match_irq(irq[1]),
        .third_match_irq(irq[2]));
    always #2 clk_sys = ~clk_sys;
    always @(negedge clk_sys) begin
        cyc <= cyc + 1;
        sub_clk_tick <= (cyc % SP) == 0;
        if (cyc > 60000) begin
            err_total++;
            results();
        end
    end
    task automatic results();
        if (err_total == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    function automatic int iv(int t, logic [2:0] s, int n, int n2);
        int d;
        case (s)
            3'h0: d = 1;
            3'h1: d = (t == 0) ? 8 : (t == 1) ? 4 : 16;
            3'h2: d = (t == 0) ? 128 : EP;
            3'h3: d = (t == 0) ? SP : 2 * EP;
            3'h4: d = (t == 0) ? n2 + 1 : 4 * EP;
            default: d = (t == 0) ? 2 * (n2 + 1) : 8 * EP;
        endcase
        return d * (n + 1);
    endfunction
    task automatic run_case(int t, logic [2:0] s, logic [7:0] n);
        int k;
        int n2;
        n2 = $unsigned($random(seed)) % 4;
        @(negedge clk_sys);
        run = 3'h0;
        // Source samples its enable on this edge too, so no race
        src_en <= 1'b0;
        @(negedge clk_sys);
        check(cnt[t], 8'h00);
        cmp[t] = n;
        sel[t] = s;
        if (t == 0) begin
            cmp[1] = 8'(n2);
            sel[1] = event_timer_pkg::CSEL_MAIN;
        end
        src_en <= 1'b1;
        run = (t == 0) ? 3'h3 : 3'(1 << t);
        // The first interval is skipped: the main prescaler runs free from reset
        repeat (2) begin
            k = 0;
            do begin
                @(negedge clk_sys);
                k++;
            end while (irq[t] !== 1'b1 && k < 3000);
        end
        check(k, iv(t, s, n, n2));
        check(cnt[t], 8'h00);
    endtask
    initial begin
        repeat (20) @(negedge clk_sys);
        reset_n = 1'b1;
        for (int t = 0; t < 3; t++)
            for (int s = 0; s < 6; s++)
                run_case(t, 3'(s), 8'($unsigned($random(seed)) % 8));
        run_case(1, 3'h0, 8'hFF);
        run_case(0, 3'h0, 8'h00);
        run_case(2, 3'h2, 8'hFF);
        run = 3'h0;
        @(negedge clk_sys);
        sel[2] = 3'h6;
        run = 3'h4;
        repeat (300) @(negedge clk_sys);
        check({irq[2], cnt[2]}, 9'h000);
        // Refused mode codes hold every counter at zero
        run = 3'h0;
        @(negedge clk_sys);
        mode = 2'h3;
        sel[0] = event_timer_pkg::CSEL_MAIN;
        sel[2] = event_timer_pkg::CSEL_MAIN;
        run = 3'h7;
        repeat (20) @(negedge clk_sys);
        check(cnt[0], 8'h00);
        check(cnt[1], 8'h00);
        check(cnt[2], 8'h00);
        check(irq, 3'h0);
        run = 3'h0;
        @(negedge clk_sys);
        mode = event_timer_pkg::MODE_PATTERN;
        run_case(2, 3'h0, 8'($unsigned($random(seed)) % 8));
        results();
    end
endmodule
